// ---- hw/clock_output_stage_pkg.sv ----
package clock_output_stage_pkg;

  // ==========================================================
  // Bus and datapath widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 32;
  localparam int ADJ_W = 34;
  localparam int LEN_W = 35;
  localparam int PATH_SHIFT = 5;

  // ==========================================================
  // Register offsets inside one path window
  localparam logic [PATH_SHIFT-1:0] OFS_DIV = 5'h00;
  localparam logic [PATH_SHIFT-1:0] OFS_HIGH = 5'h04;
  localparam logic [PATH_SHIFT-1:0] OFS_STEP_LO = 5'h08;
  localparam logic [PATH_SHIFT-1:0] OFS_STEP_HI = 5'h0C;
  localparam logic [PATH_SHIFT-1:0] OFS_CTRL = 5'h10;
  localparam logic [PATH_SHIFT-1:0] OFS_STAT = 5'h14;

  // ==========================================================
  // Values after reset and length limits
  localparam logic [DIV_W-1:0] DIV_RST = 32'h0000_0002;
  localparam logic [DIV_W-1:0] HIGH_RST = 32'h0000_0000;
  localparam logic [DIV_W-1:0] DIV_MIN = 32'h0000_0002;
  localparam logic [LEN_W-1:0] LEN_MIN = 35'h0_0000_0002;
  localparam logic [LEN_W-1:0] LEN_ONE = 35'h0_0000_0001;

  // ==========================================================
  // Differential swing codes, nominal millivolts
  typedef enum logic [1:0] {
    SWING_410MV = 2'b00,
    SWING_600MV = 2'b01,
    SWING_750MV = 2'b10,
    SWING_900MV = 2'b11
  } swing_t;

  // Divider phase
  typedef enum logic {
    PH_LOW = 1'b0,
    PH_HIGH = 1'b1
  } phase_t;

  // ==========================================================
  // Pad settings carried to the buffer, bits 10:0 of control
  typedef struct packed {
    logic [2:0] supply_level_select;
    logic [2:0] crossing_level_select;
    logic [1:0] impedance_select;
    swing_t swing_select;
    logic diff_mode;
  } pad_cfg_t;

  // Control register, bits 12:0
  typedef struct packed {
    logic enable;
    logic invert_comp;
    pad_cfg_t pad;
  } ctrl_t;

  localparam int CTRL_W = $bits(ctrl_t);
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

endpackage

// ---- hw/clock_output_stage_divider.sv ----
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Output equals source clock divided by ratio
// - Zero high width gives even duty
// - High width count sets high cycles
// - Shaped pulses are always high going
// - Duty shaping usable in every mode
// - Each path has its own phase step
// - Phase step stretches or trims halves
// - Shortening never below two high two low
// - One step reaches 2^33 high plus low
// - Signed step applied within one period
// - Even duty splits step across halves
// - Pulse mode puts step on low only
// - Unlimited successive steps accepted
// - Dual stage holds identical path copies
// - Single ended pins copy, optional inversion
// - Swing code selects 410 to 900 mV
// - Four impedance choices when single ended
module clock_output_stage_divider
  import clock_output_stage_pkg::*;
#(
  parameter int NUM_PATHS = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic [NUM_PATHS-1:0] true_pin_out,
  output logic [NUM_PATHS-1:0] comp_pin_out,
  output pad_cfg_t [NUM_PATHS-1:0] pad_cfg_out
);

  // ==========================================================
  // State types
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] high_width;
    logic [1:0] step_hi;
    logic [ADJ_W-1:0] coarse_phase_step;
    logic pending;
    ctrl_t ctrl;
    phase_t phase;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] low_len;
    logic true_pin;
    logic comp_pin;
  } path_t;

  typedef struct packed {
    path_t [NUM_PATHS-1:0] path;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // Per path helpers, also watched by the checks
  logic [NUM_PATHS-1:0] start_w;
  logic [NUM_PATHS-1:0] apply_w;
  logic [NUM_PATHS-1:0] pulse_w;
  logic [NUM_PATHS-1:0][LEN_W-1:0] base_hi_w;
  logic [NUM_PATHS-1:0][LEN_W-1:0] base_lo_w;
  logic [NUM_PATHS-1:0][LEN_W-1:0] load_hi_w;
  logic [NUM_PATHS-1:0][LEN_W-1:0] load_lo_w;

  // ==========================================================
  // Functions
  // Register select for one path and one offset
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input int p,
                                   input logic [PATH_SHIFT-1:0] ofs);
    logic [ADDR_W-PATH_SHIFT-1:0] idx;
    idx = (ADDR_W-PATH_SHIFT)'(p);
    return (addr[ADDR_W-1:PATH_SHIFT] == idx) &&
           (addr[PATH_SHIFT-1:0] == ofs);
  endfunction

  // Ratios below two behave as two
  function automatic logic [LEN_W-1:0] eff_div(input logic [DIV_W-1:0] d);
    return (d < DIV_MIN) ? LEN_MIN : LEN_W'(d);
  endfunction

  // Pulse mode when a valid high width is set
  function automatic logic is_pulse(input logic [DIV_W-1:0] d,
                                    input logic [DIV_W-1:0] hw);
    return (hw != '0) && (LEN_W'(hw) < eff_div(d));
  endfunction

  // Never trim a half below two source periods
  function automatic logic [LEN_W-1:0] clamp_len(
      input logic signed [LEN_W:0] s);
    return (s < $signed({1'b0, LEN_MIN})) ? LEN_MIN : s[LEN_W-1:0];
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic signed [LEN_W:0] adj_x;
    logic signed [LEN_W:0] h_adj;
    logic signed [LEN_W:0] l_adj;
    logic wr_step;
    adj_x = '0;
    h_adj = '0;
    l_adj = '0;
    wr_step = 1'b0;
    st_next = st_reg;
    st_next.rdata = '0;
    start_w = '0;
    apply_w = '0;
    pulse_w = '0;
    base_hi_w = '0;
    base_lo_w = '0;
    load_hi_w = '0;
    load_lo_w = '0;
    for (int p = 0; p < NUM_PATHS; p++) begin
      // Register writes
      if (wr_in && reg_hit(addr_in, p, OFS_DIV)) begin
        st_next.path[p].div = wdata_in;
      end
      if (wr_in && reg_hit(addr_in, p, OFS_HIGH)) begin
        st_next.path[p].high_width = wdata_in;
      end
      if (wr_in && reg_hit(addr_in, p, OFS_STEP_HI)) begin
        st_next.path[p].step_hi = wdata_in[1:0];
      end
      if (wr_in && reg_hit(addr_in, p, OFS_CTRL)) begin
        st_next.path[p].ctrl = wdata_in[CTRL_W-1:0];
      end
      wr_step = wr_in && reg_hit(addr_in, p, OFS_STEP_LO);
      if (wr_step) begin
        st_next.path[p].coarse_phase_step = {st_reg.path[p].step_hi,
                                             wdata_in};
      end

      // Lengths for the coming period
      // pulse width or even halves
      pulse_w[p] = is_pulse(st_reg.path[p].div, st_reg.path[p].high_width);
      base_hi_w[p] = pulse_w[p] ? LEN_W'(st_reg.path[p].high_width)
                                : (eff_div(st_reg.path[p].div) >> 1);
      base_lo_w[p] = eff_div(st_reg.path[p].div) - base_hi_w[p];
      start_w[p] = st_reg.path[p].ctrl.enable &&
                   (st_reg.path[p].phase == PH_LOW) &&
                   (st_reg.path[p].cnt == '0);
      apply_w[p] = start_w[p] && st_reg.path[p].pending;
      adj_x = $signed({{(LEN_W+1-ADJ_W){
                 st_reg.path[p].coarse_phase_step[ADJ_W-1]}},
               st_reg.path[p].coarse_phase_step});
      if (pulse_w[p]) begin
        h_adj = '0;
        l_adj = adj_x;
      end else begin
        h_adj = adj_x >>> 1;
        l_adj = adj_x - h_adj;
      end
      load_hi_w[p] = apply_w[p]
        ? clamp_len($signed({1'b0, base_hi_w[p]}) + h_adj) : base_hi_w[p];
      load_lo_w[p] = apply_w[p]
        ? clamp_len($signed({1'b0, base_lo_w[p]}) + l_adj) : base_lo_w[p];

      st_next.path[p].pending = (st_reg.path[p].pending & ~apply_w[p]) |
                                wr_step;

      // Divider counter
      // high count then remainder low
      if (!st_reg.path[p].ctrl.enable) begin
        st_next.path[p].phase = PH_LOW;
        st_next.path[p].cnt = '0;
      end else begin
        case (st_reg.path[p].phase)
          PH_LOW: begin
            if (st_reg.path[p].cnt == '0) begin
              st_next.path[p].phase = PH_HIGH;
              st_next.path[p].cnt = load_hi_w[p] - LEN_ONE;
              st_next.path[p].low_len = load_lo_w[p];
            end else begin
              st_next.path[p].cnt = st_reg.path[p].cnt - LEN_ONE;
            end
          end
          PH_HIGH: begin
            if (st_reg.path[p].cnt == '0) begin
              st_next.path[p].phase = PH_LOW;
              st_next.path[p].cnt = st_reg.path[p].low_len - LEN_ONE;
            end else begin
              st_next.path[p].cnt = st_reg.path[p].cnt - LEN_ONE;
            end
          end
          default: begin
            st_next.path[p].phase = PH_LOW;
            st_next.path[p].cnt = '0;
          end
        endcase
      end

      // Pin levels
      // pulse is high on true pin
      st_next.path[p].true_pin = (st_next.path[p].phase == PH_HIGH);
      st_next.path[p].comp_pin = st_next.path[p].true_pin ^
        (st_next.path[p].ctrl.pad.diff_mode |
         st_next.path[p].ctrl.invert_comp);

      // Read data, zero when unmapped
      if (rd_in) begin
        if (reg_hit(addr_in, p, OFS_DIV)) begin
          st_next.rdata = st_reg.path[p].div;
        end
        if (reg_hit(addr_in, p, OFS_HIGH)) begin
          st_next.rdata = st_reg.path[p].high_width;
        end
        if (reg_hit(addr_in, p, OFS_STEP_LO)) begin
          st_next.rdata = st_reg.path[p].coarse_phase_step[DATA_W-1:0];
        end
        if (reg_hit(addr_in, p, OFS_STEP_HI)) begin
          st_next.rdata = {30'h0000_0000, st_reg.path[p].step_hi};
        end
        if (reg_hit(addr_in, p, OFS_CTRL)) begin
          st_next.rdata = {19'h0_0000, st_reg.path[p].ctrl};
        end
        if (reg_hit(addr_in, p, OFS_STAT)) begin
          st_next.rdata = {29'h0000_0000, pulse_w[p],
                           st_reg.path[p].true_pin, st_reg.path[p].pending};
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      for (int p = 0; p < NUM_PATHS; p++) begin
        st_reg.path[p].div <= DIV_RST;
        st_reg.path[p].high_width <= HIGH_RST;
        st_reg.path[p].ctrl <= CTRL_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    rdata_out = st_reg.rdata;
    for (int p = 0; p < NUM_PATHS; p++) begin
      true_pin_out[p] = st_reg.path[p].true_pin;
      comp_pin_out[p] = st_reg.path[p].comp_pin;
      pad_cfg_out[p] = st_reg.path[p].ctrl.pad;
    end
  end

  // ==========================================================
  // Checks on path zero
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  period_total_a: assert property (
    start_w[0] && !apply_w[0] |->
      (load_hi_w[0] + load_lo_w[0]) == eff_div(st_reg.path[0].div))
    else $error("period length differs from ratio");

  even_halves_a: assert property (
    start_w[0] && !apply_w[0] && st_reg.path[0].high_width == '0 |->
      load_hi_w[0] == (eff_div(st_reg.path[0].div) >> 1))
    else $error("even duty high length wrong");

  high_two_a: assert property (
    start_w[0] && load_hi_w[0] == LEN_MIN |=>
      true_pin_out[0] [*2] ##1 !true_pin_out[0])
    else $error("two cycle high not held");

  low_three_a: assert property (
    $fell(true_pin_out[0]) && st_reg.path[0].ctrl.enable &&
    st_reg.path[0].low_len == 35'h0_0000_0003 |->
      !true_pin_out[0] [*3] ##1 true_pin_out[0])
    else $error("low remainder length wrong");

  pulse_low_only_a: assert property (
    apply_w[0] && pulse_w[0] |->
      load_hi_w[0] == LEN_W'(st_reg.path[0].high_width))
    else $error("pulse width changed by step");

  step_floor_a: assert property (
    apply_w[0] |-> load_hi_w[0] >= LEN_MIN && load_lo_w[0] >= LEN_MIN)
    else $error("shortened below two and two");

  split_even_a: assert property (
    apply_w[0] && !pulse_w[0] && load_hi_w[0] > LEN_MIN &&
    load_lo_w[0] > LEN_MIN |->
      (load_lo_w[0] - base_lo_w[0]) - (load_hi_w[0] - base_hi_w[0]) <= 1)
    else $error("step not split across halves");

  one_period_a: assert property (
    apply_w[0] && !(wr_in && reg_hit(addr_in, 0, OFS_STEP_LO)) |=>
      !st_reg.path[0].pending)
    else $error("step not consumed at period start");

  comp_copy_a: assert property (
    !st_reg.path[0].ctrl.pad.diff_mode && !st_reg.path[0].ctrl.invert_comp
      |-> comp_pin_out[0] == true_pin_out[0])
    else $error("complement pin not a copy");

  swing_write_a: assert property (
    wr_in && reg_hit(addr_in, 0, OFS_CTRL) |=>
      pad_cfg_out[0].swing_select == swing_t'($past(wdata_in[2:1])))
    else $error("swing code not taken");

  // Low-going copy on the complement pin when inversion is set
  comp_invert_a: assert property (
    st_reg.path[0].ctrl.invert_comp && !st_reg.path[0].ctrl.pad.diff_mode
      |-> comp_pin_out[0] != true_pin_out[0])
    else $error("complement pin not inverted");

  pulse_run_c: cover property (pulse_w[0] && $rose(true_pin_out[0]));
  step_taken_c: cover property (apply_w[0] && !pulse_w[0]);
  step_pulse_c: cover property (apply_w[0] && pulse_w[0]);
  step_clamp_c: cover property (apply_w[0] && load_lo_w[0] == LEN_MIN);
  diff_run_c: cover property (st_reg.path[0].ctrl.pad.diff_mode &&
                              $rose(true_pin_out[0]));

endmodule // clock_output_stage_divider

// ---- sim/clock_receiver_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Receiver on one output pin: measures the last high and low run
module clock_receiver_model (
  input wire logic clk_in,
  input wire logic pin_in,
  output logic [31:0] hi_len_out,
  output logic [31:0] lo_len_out
);
  logic last_reg = 1'b0;
  logic [31:0] cnt_reg = 32'h0000_0000;

  // Count source periods per level, latch the run length on a change
  always @(posedge clk_in) begin
    if (pin_in !== last_reg) begin
      if (last_reg) begin
        hi_len_out <= cnt_reg;
      end else begin
        lo_len_out <= cnt_reg;
      end
      cnt_reg <= 32'h0000_0001;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
    last_reg <= pin_in;
  end
endmodule // clock_receiver_model

// ---- sim/test_clock_output_stage_divider.sv ----
`timescale 1ns/1ps
module test_clock_output_stage_divider;
  import clock_output_stage_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = 8'h00;
  logic [DATA_W-1:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic [1:0] true_pin_out;
  logic [1:0] comp_pin_out;
  pad_cfg_t [1:0] pad_cfg_out;
  logic [31:0] hi_len [2];
  logic [31:0] lo_len [2];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  // ==========================================================
  // Design, receivers, clock and watchdog
  clock_output_stage_divider #(.NUM_PATHS(2)) u_clock_output_stage_divider (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .true_pin_out(true_pin_out),
    .comp_pin_out(comp_pin_out), .pad_cfg_out(pad_cfg_out));

  for (genvar i = 0; i < 2; i++) begin : g_rx
    clock_receiver_model u_clock_receiver_model (.clk_in(clk_in),
      .pin_in(true_pin_out[i]), .hi_len_out(hi_len[i]),
      .lo_len_out(lo_len[i]));
  end

  always #50 clk_in = ~clk_in;

  // Cut a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int p, input logic [4:0] ofs, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= {p[2:0], ofs};
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input int p, input logic [4:0] ofs, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= {p[2:0], ofs};
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out, e);
  endtask

  task automatic wait_pin(input int p, input logic lvl);
    for (int n = 0; n < 400; n++) begin
      @(posedge clk_in);
      #1;
      if (true_pin_out[p] === lvl) return;
    end
    failures++;
    $display("ERROR %0t: pin stuck", $time);
  endtask

  // Skip one period so that new settings are surely in force
  task automatic settle(input int p);
    wait_pin(p, 1'b0);
    wait_pin(p, 1'b1);
  endtask

  // Check high and low length of the next period that starts
  task automatic measure(input int p, input logic [31:0] eh,
                         input logic [31:0] el);
    settle(p);
    settle(p);
    @(posedge clk_in);
    #1;
    check(hi_len[p], eh);
    check(lo_len[p], el);
  endtask

  // Load a signed step while the pin is high, well before the next start
  task automatic step(input int p, input int s);
    logic [33:0] v;
    v = 34'(s);
    settle(p);
    wr(p, OFS_STEP_HI, {30'h0, v[33:32]});
    wr(p, OFS_STEP_LO, v[31:0]);
  endtask

  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    #1;
    check(true_pin_out, 2'b00);
    rd(0, OFS_DIV, 32'h0000_0002);
    rd(0, OFS_HIGH, 32'h0000_0000);
    rd(0, OFS_CTRL, 32'h0000_0000);
    wr(0, OFS_DIV, 32'hFFFF_FFFF);
    rd(0, OFS_DIV, 32'hFFFF_FFFF);
    wr(0, 5'h1C, 32'h1234_5678);
    rd(0, 5'h1C, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_even();
    wr(0, OFS_DIV, 32'h0000_0007);
    wr(0, OFS_CTRL, 32'h0000_1000);
    #1;
    check(true_pin_out[0], 1'b0);
    @(posedge clk_in);
    #1;
    check(true_pin_out[0], 1'b1);
    measure(0, 32'd3, 32'd4);
    wr(0, OFS_DIV, 32'h0000_0006);
    settle(0);
    measure(0, 32'd3, 32'd3);
    wr(1, OFS_DIV, 32'h0000_0008);
    wr(1, OFS_CTRL, 32'h0000_1000);
    measure(1, 32'd4, 32'd4);
    measure(0, 32'd3, 32'd3);
    // High width not below the ratio falls back to even duty
    wr(1, OFS_HIGH, 32'h0000_0008);
    measure(1, 32'd4, 32'd4);
    // Ratio zero behaves as two
    wr(1, OFS_DIV, 32'h0000_0000);
    measure(1, 32'd1, 32'd1);
    $display("test even done");
  endtask

  task automatic t_pulse();
    // High width kept below the ratio, ratio above 4
    wr(0, OFS_DIV, 32'h0000_0014);
    wr(0, OFS_HIGH, 32'h0000_0006);
    wr(0, OFS_CTRL, 32'h0000_1800);
    settle(0);
    measure(0, 32'd6, 32'd14);
    check(comp_pin_out[0], !true_pin_out[0]);
    $display("test pulse done");
  endtask

  task automatic t_pad();
    for (int k = 0; k < 4; k++) begin
      wr(0, OFS_CTRL, 32'h0000_1000 | (k << 3) | (k << 1) | (k & 1));
      #1;
      check(pad_cfg_out[0].swing_select, k);
      check(pad_cfg_out[0].impedance_select, k);
      @(posedge clk_in);
      #1;
      check(comp_pin_out[0], true_pin_out[0] ^ k[0]);
    end
    settle(0);
    measure(0, 32'd6, 32'd14);
    $display("test pad done");
  endtask

  task automatic t_step();
    // Steps from 5 down to -30, the last one trimmed to the floor, ratio 20
    step(0, 5);
    measure(0, 32'd6, 32'd19);
    wr(0, OFS_HIGH, 32'h0000_0000);
    settle(0);
    step(0, 4);
    measure(0, 32'd12, 32'd12);
    measure(0, 32'd10, 32'd10);
    step(0, -4);
    measure(0, 32'd8, 32'd8);
    step(0, 3);
    measure(0, 32'd11, 32'd12);
    step(0, -30);
    measure(0, 32'd2, 32'd2);
    $display("test step done");
  endtask

  task automatic t_regs();
    // Mid-run reset brings registers, pins and pads back to defaults
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check(true_pin_out, 2'b00);
    check(pad_cfg_out[1], 11'h000);
    rd(0, OFS_DIV, 32'h0000_0002);
    rd(1, OFS_CTRL, 32'h0000_0000);
    // A step on a stopped path stays pending and reads back
    wr(0, OFS_STEP_HI, 32'h0000_0002);
    wr(0, OFS_STEP_LO, 32'h8000_0001);
    wr(0, OFS_HIGH, 32'h0000_0001);
    rd(0, OFS_STEP_HI, 32'h0000_0002);
    rd(0, OFS_STEP_LO, 32'h8000_0001);
    rd(0, OFS_STAT, 32'h0000_0005);
    // Read data stand for one cycle only
    @(posedge clk_in);
    #1;
    check(rdata_out, 32'h0000_0000);
    // Supply and crossing codes pass to the buffer
    wr(1, OFS_CTRL, 32'h0000_0765);
    #1;
    check(pad_cfg_out[1], 11'h765);
    check(comp_pin_out[1], 1'b1);
    $display("test regs done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_even();
    t_pulse();
    t_pad();
    t_step();
    t_regs();
    finish_test();
  end
endmodule // test_clock_output_stage_divider
